/* rtl/cmp_latch_pkg.sv */
// constants for the comparator back end: register map, field positions,
// reset values and divider figures.
// assumes a 32-bit AXI4-Lite register bus and one 40 MHz system clock.

package cmp_latch_pkg;

	// ----------------------------------------------------------------
	// register byte addresses
	// ----------------------------------------------------------------
	localparam logic [4:0] ADDR_CMP_ONE   = 5'h00;
	localparam logic [4:0] ADDR_CMP_TWO   = 5'h04;
	localparam logic [4:0] ADDR_SHARED    = 5'h08;
	localparam logic [4:0] ADDR_LATCH_MN  = 5'h0C;
	localparam logic [4:0] ADDR_LATCH_PS  = 5'h10;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CMP_RESULT_BIT   = 6;
	localparam int CMP_UNUSED_BIT   = 3;
	localparam int SH_MIRROR1_BIT   = 7;
	localparam int SH_MIRROR2_BIT   = 6;
	localparam int SH_ALT_CLK_BIT   = 4;
	localparam int SH_HYS1_BIT      = 3;
	localparam int SH_HYS2_BIT      = 2;
	localparam int SH_GATE_SEL_BIT  = 1;
	localparam int SH_SYNC_BIT      = 0;
	localparam int LM_MUX2_BIT      = 7;
	localparam int LM_MUX1_BIT      = 6;
	localparam int LM_SET_EN_BIT    = 5;
	localparam int LM_RST_EN_BIT    = 4;
	localparam int LM_SET_PULSE_BIT = 3;
	localparam int LM_RST_PULSE_BIT = 2;
	localparam int LM_CLK_EN_BIT    = 0;
	localparam int LP_PRESCALE_LSB  = 6;

	// ----------------------------------------------------------------
	// reset values and masks of writable bits
	// ----------------------------------------------------------------
	localparam logic [7:0] CMP_RESET     = 8'h00;
	localparam logic [7:0] SHARED_RESET  = 8'h02;
	localparam logic [7:0] LATCH_RESET   = 8'h00;
	localparam logic [7:0] PRESC_RESET   = 8'h00;
	localparam logic [7:0] CMP_WMASK     = 8'hB7;
	localparam logic [7:0] SHARED_WMASK  = 8'h1F;
	localparam logic [7:0] LATCH_WMASK   = 8'hF1;
	localparam logic [7:0] PRESC_WMASK   = 8'hC0;

	// ----------------------------------------------------------------
	// dividers and bus answers
	// ----------------------------------------------------------------
	localparam int         SET_CLK_BASE_LOG2 = 4;
	localparam int         SET_CLK_CNT_W     = 7;
	localparam logic [1:0] TIMER_DIV_RISE    = 2'h0;
	localparam logic [1:0] TIMER_DIV_FALL    = 2'h2;
	localparam logic [1:0] RESP_OKAY         = 2'h0;
	localparam logic [1:0] RESP_SLVERR       = 2'h2;

endpackage : cmp_latch_pkg

/* rtl/cmp_input_sync.sv */
// two-flop synchroniser, one stage pair per bit.
// assumes inputs may change at any time relative to aclk.
`timescale 1ns/1ps
`default_nettype none

module cmp_input_sync #(
	parameter int WIDTH = 2
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic [WIDTH-1:0] async_in,
	output var  logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_reg;

	// first stage feeds only the second stage
	for (genvar i = 0; i < WIDTH; i++)
	begin : g_bit
		always_ff @(posedge aclk)
		begin
			if (!aresetn)
			begin
				meta_reg[i] <= 1'b0;
				sync_out[i] <= 1'b0;
			end
			else
			begin
				meta_reg[i] <= async_in[i];
				sync_out[i] <= meta_reg[i];
			end
		end
	end

endmodule : cmp_input_sync

`default_nettype wire

/* rtl/set_clock_divider.sv */
// set-clock pulser: one-cycle pulse once per 16, 32, 64 or 128 cycles.
// assumes enable and prescale come from registers in the same clock domain.
`timescale 1ns/1ps
`default_nettype none

module set_clock_divider (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       enable,
	input  wire logic [1:0] prescale,
	output var  logic       pulse
);

	localparam int CW = cmp_latch_pkg::SET_CLK_CNT_W;

	logic [CW-1:0] count_reg;
	logic [CW-1:0] last_count;

	// terminal count is 2^(4+code) - 1
	assign last_count = CW'((1 << (cmp_latch_pkg::SET_CLK_BASE_LOG2 + int'(prescale))) - 1);

	always_ff @(posedge aclk)
	begin
		if (!aresetn || !enable)
		begin
			count_reg <= '0;
			pulse     <= 1'b0;
		end
		else if (count_reg >= last_count)
		begin
			count_reg <= '0;
			pulse     <= 1'b1;
		end
		else
		begin
			count_reg <= count_reg + CW'(1);
			pulse     <= 1'b0;
		end
	end

endmodule : set_clock_divider

`default_nettype wire

/* rtl/cmp_latch_core.sv */
// comparator digital back end: registers, timer clock and gate selection,
// comparator-2 capture, set/reset latch and port output multiplexers.
// assumes AXI4-Lite master on aclk; comparator results are asynchronous;
// timer prescaler inputs are synchronous to aclk.
//
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module cmp_latch_core (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite slave
	input  wire logic [4:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [4:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// comparators
	input  wire logic        cmp1_result,
	input  wire logic        cmp2_result,
	output var  logic [7:0]  cmp1_config,
	output var  logic [7:0]  cmp2_config,
	output var  logic        cmp1_hysteresis_enable,
	output var  logic        cmp2_hysteresis_enable,
	// timer
	input  wire logic        timer_prescale_active,
	input  wire logic        timer_prescale_level,
	input  wire logic        timer_gate_pin,
	output var  logic        timer_clock_tick,
	output var  logic        timer_gate,
	output var  logic        synced_cmp2_result,
	// port logic
	output var  logic        port1_out,
	output var  logic        port2_out
);

	// ----------------------------------------------------------------
	// registers and internal state
	// ----------------------------------------------------------------
	logic [7:0]  cmp_one_reg;
	logic [7:0]  cmp_two_reg;
	logic [7:0]  shared_reg;
	logic [7:0]  latch_main_reg;
	logic [7:0]  latch_presc_reg;
	logic        set_pulse_reg;
	logic        reset_pulse_reg;
	logic        latch_q_reg;
	logic [1:0]  cmp_sync;
	logic        set_clk_pulse;
	logic [1:0]  timer_div_reg;
	logic        presc_prev_reg;
	logic        capture_reg;
	logic        timer_fall;
	logic        timer_rise;
	logic        synced_cmp2;
	logic        latch_set;
	logic        latch_rst;
	logic        wr_fire;
	logic        wr_map;
	logic        rd_map;
	logic [7:0]  wr_byte;
	logic [7:0]  rd_byte;

	// ----------------------------------------------------------------
	// leaf instances
	// ----------------------------------------------------------------
	cmp_input_sync #(
		.WIDTH (2)
	) u_sync (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.async_in ({cmp2_result, cmp1_result}),
		.sync_out (cmp_sync)
	);

	set_clock_divider u_set_clk (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.enable   (latch_main_reg[cmp_latch_pkg::LM_CLK_EN_BIT]),
		.prescale (latch_presc_reg[cmp_latch_pkg::LP_PRESCALE_LSB +: 2]),
		.pulse    (set_clk_pulse)
	);

	// ----------------------------------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------------------------------
	assign wr_fire = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
	assign wr_byte = s_axi_wdata[7:0];

	always_comb
	begin
		unique case (s_axi_awaddr)
			cmp_latch_pkg::ADDR_CMP_ONE,
			cmp_latch_pkg::ADDR_CMP_TWO,
			cmp_latch_pkg::ADDR_SHARED,
			cmp_latch_pkg::ADDR_LATCH_MN,
			cmp_latch_pkg::ADDR_LATCH_PS: wr_map = 1'b1;
			default:                      wr_map = 1'b0;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= cmp_latch_pkg::RESP_OKAY;
		end
		else
		begin
			// address and data are taken together on one edge
			s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready
				&& !s_axi_bvalid;
			s_axi_wready  <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready
				&& !s_axi_bvalid;
			if (wr_fire)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_map ? cmp_latch_pkg::RESP_OKAY
					: cmp_latch_pkg::RESP_SLVERR;
			end
			else if (s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// control registers
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cmp_one_reg     <= cmp_latch_pkg::CMP_RESET;
			cmp_two_reg     <= cmp_latch_pkg::CMP_RESET;
			shared_reg      <= cmp_latch_pkg::SHARED_RESET;
			latch_main_reg  <= cmp_latch_pkg::LATCH_RESET;
			latch_presc_reg <= cmp_latch_pkg::PRESC_RESET;
		end
		else if (wr_fire && s_axi_wstrb[0])
		begin
			unique case (s_axi_awaddr)
				cmp_latch_pkg::ADDR_CMP_ONE:
					cmp_one_reg <= wr_byte & cmp_latch_pkg::CMP_WMASK;
				cmp_latch_pkg::ADDR_CMP_TWO:
					cmp_two_reg <= wr_byte & cmp_latch_pkg::CMP_WMASK;
				cmp_latch_pkg::ADDR_SHARED:
					shared_reg <= wr_byte & cmp_latch_pkg::SHARED_WMASK;
				cmp_latch_pkg::ADDR_LATCH_MN:
					latch_main_reg <= wr_byte & cmp_latch_pkg::LATCH_WMASK;
				cmp_latch_pkg::ADDR_LATCH_PS:
					latch_presc_reg <= wr_byte & cmp_latch_pkg::PRESC_WMASK;
				default:
					cmp_one_reg <= cmp_one_reg;
			endcase
		end
	end

	// software pulse bits: set by a write of 1, gone one cycle later
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			set_pulse_reg   <= 1'b0;
			reset_pulse_reg <= 1'b0;
		end
		else
		begin
			set_pulse_reg   <= wr_fire && s_axi_wstrb[0]
				&& (s_axi_awaddr == cmp_latch_pkg::ADDR_LATCH_MN)
				&& wr_byte[cmp_latch_pkg::LM_SET_PULSE_BIT];
			reset_pulse_reg <= wr_fire && s_axi_wstrb[0]
				&& (s_axi_awaddr == cmp_latch_pkg::ADDR_LATCH_MN)
				&& wr_byte[cmp_latch_pkg::LM_RST_PULSE_BIT];
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------------------------------
	// reads only look; no state changes on a read
	always_comb
	begin
		rd_map  = 1'b1;
		rd_byte = 8'h00;
		unique case (s_axi_araddr)
			cmp_latch_pkg::ADDR_CMP_ONE:
			begin
				rd_byte = cmp_one_reg;
				rd_byte[cmp_latch_pkg::CMP_RESULT_BIT] = cmp_sync[0];
			end
			cmp_latch_pkg::ADDR_CMP_TWO:
			begin
				rd_byte = cmp_two_reg;
				rd_byte[cmp_latch_pkg::CMP_RESULT_BIT] = cmp_sync[1];
			end
			cmp_latch_pkg::ADDR_SHARED:
			begin
				rd_byte = shared_reg;
				rd_byte[cmp_latch_pkg::SH_MIRROR1_BIT] = cmp_sync[0];
				rd_byte[cmp_latch_pkg::SH_MIRROR2_BIT] = cmp_sync[1];
			end
			cmp_latch_pkg::ADDR_LATCH_MN: rd_byte = latch_main_reg;
			cmp_latch_pkg::ADDR_LATCH_PS: rd_byte = latch_presc_reg;
			default:                      rd_map  = 1'b0;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= cmp_latch_pkg::RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arready && s_axi_arvalid)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= {24'h00_0000, rd_byte};
				s_axi_rresp  <= rd_map ? cmp_latch_pkg::RESP_OKAY
					: cmp_latch_pkg::RESP_SLVERR;
			end
			else if (s_axi_rready)
			begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// timer clock source and edges
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			timer_div_reg  <= 2'h0;
			presc_prev_reg <= 1'b0;
		end
		else
		begin
			timer_div_reg  <= timer_div_reg + 2'h1;
			presc_prev_reg <= timer_prescale_level;
		end
	end

	// divide-by-4 clock is high for counts 0..1, low for 2..3
	always_comb
	begin
		if (timer_prescale_active)
		begin
			timer_fall = presc_prev_reg && !timer_prescale_level;
			timer_rise = 1'b0;
		end
		else if (shared_reg[cmp_latch_pkg::SH_ALT_CLK_BIT])
		begin
			timer_fall = 1'b1;
			timer_rise = 1'b1;
		end
		else
		begin
			timer_fall = (timer_div_reg == cmp_latch_pkg::TIMER_DIV_FALL);
			timer_rise = (timer_div_reg == cmp_latch_pkg::TIMER_DIV_RISE);
		end
		if (shared_reg[cmp_latch_pkg::SH_ALT_CLK_BIT])
		begin
			timer_rise = 1'b1;
		end
		else
		begin
			timer_rise = (timer_div_reg == cmp_latch_pkg::TIMER_DIV_RISE);
		end
	end

	// ----------------------------------------------------------------
	// comparator 2 capture and timer gate
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			capture_reg <= 1'b0;
		end
		else if (timer_fall)
		begin
			capture_reg <= cmp_sync[1];
		end
	end

	assign synced_cmp2 = shared_reg[cmp_latch_pkg::SH_SYNC_BIT] ? capture_reg
		: cmp_sync[1];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			timer_clock_tick   <= 1'b0;
			timer_gate         <= 1'b1;
			synced_cmp2_result <= 1'b0;
		end
		else
		begin
			timer_clock_tick   <= timer_rise;
			timer_gate         <= shared_reg[cmp_latch_pkg::SH_GATE_SEL_BIT]
				? timer_gate_pin : synced_cmp2;
			synced_cmp2_result <= synced_cmp2;
		end
	end

	// ----------------------------------------------------------------
	// set/reset latch
	// ----------------------------------------------------------------
	assign latch_set = (cmp_sync[0] && latch_main_reg[cmp_latch_pkg::LM_SET_EN_BIT])
		|| set_pulse_reg || set_clk_pulse;
	assign latch_rst = (cmp_sync[1] && latch_main_reg[cmp_latch_pkg::LM_RST_EN_BIT])
		|| reset_pulse_reg;

	// holds with both inputs low; reset dominates
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			latch_q_reg <= 1'b0;
		end
		else if (latch_rst)
		begin
			latch_q_reg <= 1'b0;
		end
		else if (latch_set)
		begin
			latch_q_reg <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// output multiplexers and comparator controls
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			port1_out              <= 1'b0;
			port2_out              <= 1'b0;
			cmp1_config            <= cmp_latch_pkg::CMP_RESET;
			cmp2_config            <= cmp_latch_pkg::CMP_RESET;
			cmp1_hysteresis_enable <= 1'b0;
			cmp2_hysteresis_enable <= 1'b0;
		end
		else
		begin
			port1_out <= latch_main_reg[cmp_latch_pkg::LM_MUX1_BIT]
				? latch_q_reg : cmp_sync[0];
			port2_out <= latch_main_reg[cmp_latch_pkg::LM_MUX2_BIT]
				? !latch_q_reg : cmp_sync[1];
			cmp1_config            <= cmp_one_reg;
			cmp2_config            <= cmp_two_reg;
			cmp1_hysteresis_enable <= shared_reg[cmp_latch_pkg::SH_HYS1_BIT];
			cmp2_hysteresis_enable <= shared_reg[cmp_latch_pkg::SH_HYS2_BIT];
		end
	end

endmodule : cmp_latch_core

`default_nettype wire

/* tb/cmp_latch_assertions.sv */
// checker: bus handshake and output relations of the comparator back end.
// assumes it is bound to cmp_latch_core and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module cmp_latch_assertions (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        cmp1_hysteresis_enable,
	input wire logic        timer_gate
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_awready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("awready held longer than one cycle");
	a_ready_pair: assert property (s_axi_awready == s_axi_wready)
		else $error("awready and wready apart");
	a_write_answer: assert property (s_axi_awready && s_axi_awvalid && s_axi_wvalid |=> s_axi_bvalid)
		else $error("no write response after handshake");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	a_read_answer: assert property (s_axi_arready && s_axi_arvalid |=> s_axi_rvalid)
		else $error("no read data after handshake");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
		else $error("upper read bits not zero");
	a_hys_written: assert property (!$stable(cmp1_hysteresis_enable) |-> $past(s_axi_awready) || $past(s_axi_awready, 2))
		else $error("hysteresis enable moved without a write");
	a_gate_reset: assert property ($rose(aresetn) |-> timer_gate)
		else $error("gate not high out of reset");
endmodule : cmp_latch_assertions

bind cmp_latch_core cmp_latch_assertions u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .cmp1_hysteresis_enable, .timer_gate);

`default_nettype wire

/* tb/cmp_partner.sv */
// partner: two comparator outputs and the timer prescaler output.
// assumes the bench sets the wanted comparator levels and the prescaler run flag.
`timescale 1ns/1ps
`default_nettype none

module cmp_partner (
	input  wire logic aclk,
	input  wire logic c1_want,
	input  wire logic c2_want,
	input  wire logic presc_run,
	output wire logic cmp1_result,
	output wire logic cmp2_result,
	output wire logic timer_prescale_level
);
	logic [1:0] div = 2'h0;

	// comparators settle off the clock edge, unrelated to it
	assign #3 cmp1_result = c1_want;
	assign #7 cmp2_result = c2_want;
	assign timer_prescale_level = div[1];

	// prescaler output stands still while not running
	always_ff @(posedge aclk)
		if (presc_run)
			div <= div + 2'h1;
endmodule : cmp_partner

`default_nettype wire

/* tb/comparator_sync_sr_latch_bench.sv */
// bench: self-checking test of the comparator back end against a register model.
// assumes cmp_latch_core, cmp_partner and the checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
	$display("wrong value %s expected %h seen %h", nm, e, g); end end

module comparator_sync_sr_latch_bench;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [4:0]  s_axi_awaddr = 5'h00;
	logic [4:0]  s_axi_araddr = 5'h00;
	logic [31:0] s_axi_wdata = 32'h00000000;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        timer_prescale_active = 1'b0, timer_gate_pin = 1'b0;
	logic        c1 = 1'b0, c2 = 1'b0, presc_run = 1'b0;
	wire logic   cmp1_result, cmp2_result, timer_prescale_level;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [7:0]  cmp1_config, cmp2_config;
	logic        cmp1_hysteresis_enable, cmp2_hysteresis_enable;
	logic        timer_clock_tick, timer_gate, synced_cmp2_result, port1_out, port2_out;
	logic [7:0]  mdl [5] = '{8'h00, 8'h00, 8'h02, 8'h00, 8'h00};
	logic [10:0] steps [8] = '{11'h641, 11'h620, 11'h705, 11'h701, 11'h703, 11'h782,
		11'h786, 11'h7C2};
	int          fail_count = 0;
	int          comparisons = 0;
	int          cyc = 0;
	int          seed = 10293;

	always #12.5 aclk = ~aclk;
	always @(posedge aclk) cyc <= cyc + 1;

	cmp_partner u_far (.aclk, .c1_want(c1), .c2_want(c2), .presc_run, .cmp1_result,
		.cmp2_result, .timer_prescale_level);

	cmp_latch_core DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmp1_result, .cmp2_result, .cmp1_config,
		.cmp2_config, .cmp1_hysteresis_enable, .cmp2_hysteresis_enable, .timer_prescale_active,
		.timer_prescale_level, .timer_gate_pin, .timer_clock_tick, .timer_gate,
		.synced_cmp2_result, .port1_out, .port2_out);

	task automatic end_of_test;
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test

	// one bus transfer; the answer ready is raised late so the slave must hold
	task automatic xfer(input logic rd, input logic [4:0] a, input logic [7:0] d,
		output logic [31:0] q, output logic [1:0] r);
		int n;
		@(posedge aclk);
		if (rd)
			s_axi_araddr <= a;
		else
			s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_arvalid <= rd;
		s_axi_awvalid <= !rd;
		s_axi_wvalid <= !rd;
		for (n = 0; n < 40; n++)
		begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
			if ((rd ? s_axi_rvalid && s_axi_rready : s_axi_bvalid && s_axi_bready) === 1'b1) break;
			if (n == 3) s_axi_rready <= rd;
			if (n == 3) s_axi_bready <= !rd;
		end
		q = s_axi_rdata;
		r = rd ? s_axi_rresp : s_axi_bresp;
		s_axi_rready <= 1'b0;
		s_axi_bready <= 1'b0;
		if (n == 40)
		begin
			fail_count++;
			end_of_test();
		end
	endtask : xfer

	function automatic logic [7:0] wmask(input int i);
		case (i)
			0, 1: return cmp_latch_pkg::CMP_WMASK;
			2: return cmp_latch_pkg::SHARED_WMASK;
			3: return cmp_latch_pkg::LATCH_WMASK;
			default: return cmp_latch_pkg::PRESC_WMASK;
		endcase
	endfunction : wmask

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		logic [31:0] q;
		logic [1:0]  r;
		xfer(1'b0, a, d, q, r);
		if (a < 5'h14) mdl[a >> 2] = d & wmask(int'(a >> 2));
		`CHK("bresp", (a < 5'h14) ? cmp_latch_pkg::RESP_OKAY : cmp_latch_pkg::RESP_SLVERR, r)
	endtask : wr

	// read compared with the model plus live comparator bits
	task automatic rdc(input logic [4:0] a);
		logic [31:0] q;
		logic [1:0]  r;
		logic [7:0]  e;
		int          i;
		i = int'(a >> 2);
		e = (i < 5) ? mdl[i] : 8'h00;
		if (i == 0) e[6] = c1;
		if (i == 1) e[6] = c2;
		if (i == 2) e[7:6] = {c1, c2};
		xfer(1'b1, a, 8'h00, q, r);
		`CHK("rdata", {24'h000000, e}, q)
		`CHK("rresp", (i < 5) ? cmp_latch_pkg::RESP_OKAY : cmp_latch_pkg::RESP_SLVERR, r)
	endtask : rdc

	task automatic idle(input int n);
		repeat (n) @(posedge aclk);
	endtask : idle

	task automatic wait_p1(input logic v);
		int n;
		for (n = 0; n < 400 && port1_out !== v; n++) @(posedge aclk);
		if (n == 400)
		begin
			fail_count++;
			end_of_test();
		end
	endtask : wait_p1

	initial
	begin
		int k;
		int n;
		int t0;
		idle(4);
		aresetn <= 1'b1;
		for (k = 0; k < 24; k += 4) rdc(5'(k));
		wr(5'h14, 8'hFF);
		// shared write forces hysteresis 1 on so its check can trip
		for (k = 0; k < 20; k += 4) wr(5'(k), 8'($random(seed)) | ((k == 8) ? 8'h08 : 8'h00));
		for (k = 0; k < 20; k += 4) rdc(5'(k));
		`CHK("hys1", mdl[2][3], cmp1_hysteresis_enable)
		`CHK("hys2", mdl[2][2], cmp2_hysteresis_enable)
		`CHK("config1", mdl[0], cmp1_config & cmp_latch_pkg::CMP_WMASK)
		`CHK("config2", mdl[1], cmp2_config & cmp_latch_pkg::CMP_WMASK)
		for (k = 0; k < 20; k += 4) wr(5'(k), (k == 8) ? 8'h02 : 8'h00);
		for (k = 0; k < 4; k++)
		begin
			{c1, c2} <= 2'(k);
			idle(6);
			rdc(5'h08);
			`CHK("port1", c1, port1_out)
			`CHK("port2", c2, port2_out)
		end
		for (k = 0; k < 8; k++)
		begin
			{c1, c2} <= steps[k][2:1];
			wr(5'h0C, steps[k][10:3]);
			idle(6);
			rdc(5'h0C);
			`CHK("latch q", steps[k][0], port1_out)
			`CHK("latch nq", !steps[k][0], port2_out)
		end
		{c1, c2} <= 2'b00;
		for (k = 0; k < 4; k++)
		begin
			wr(5'h10, 8'(k << 6));
			wr(5'h0C, 8'h45);
			wait_p1(1'b0);
			wait_p1(1'b1);
			t0 = cyc;
			wr(5'h0C, 8'h45);
			wait_p1(1'b0);
			wait_p1(1'b1);
			`CHK("set clock period", 16 << k, cyc - t0)
		end
		wr(5'h0C, 8'h00);
		for (k = 1; k >= 0; k--)
		begin
			wr(5'h08, 8'(k * 16 + 2));
			n = 0;
			repeat (40)
			begin
				@(posedge aclk);
				n += (timer_clock_tick === 1'b1);
			end
			`CHK("ticks", k ? 40 : 10, n)
		end
		for (k = 0; k < 6; k++)
		begin
			if (k == 2) wr(5'h08, 8'h10);
			if (k == 4) wr(5'h08, 8'h11);
			// pin runs opposite to comparator 2 once the gate follows the comparator
			timer_gate_pin <= k[0] ^ (k >= 2);
			c2 <= k[0];
			idle(8);
			`CHK("gate", k[0], timer_gate)
			if (k >= 2) `CHK("synced", k[0], synced_cmp2_result)
		end
		timer_prescale_active <= 1'b1;
		c2 <= 1'b0;
		idle(12);
		`CHK("capture held", 1'b1, synced_cmp2_result)
		presc_run <= 1'b1;
		idle(12);
		`CHK("capture taken", 1'b0, synced_cmp2_result)
		end_of_test();
	end
endmodule : comparator_sync_sr_latch_bench

`default_nettype wire
